// >>> lmb_pkg.sv
// Package for the local memory bus port: cycle codes, states, timing.
// Assumes a single 25 MHz core clock shared by the whole port.
package lmb_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ = 25;
  localparam int CLK_PERIOD_NS = 40;
  // Least row precharge time in ns, converted to whole cycles (round up)
  localparam int RAS_PRE_NS = 80;
  localparam int RAS_PRE_CYC = (RAS_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least time from row strobe to column strobe
  localparam int RCD_NS = 40;
  localparam int RCD_CYC = (RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PRE_CNT = 4'(RAS_PRE_CYC);
  localparam logic [3:0] RCD_CNT = 4'(RCD_CYC);

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int LANES = 8;

  // ****************************************
  // Bus width codes
  // ****************************************
  localparam logic [1:0] BW_8 = 2'h0;
  localparam logic [1:0] BW_16 = 2'h1;
  localparam logic [1:0] BW_32 = 2'h2;
  localparam logic [1:0] BW_64 = 2'h3;

  // ****************************************
  // Request types
  // ****************************************
  localparam logic [1:0] RQ_READ = 2'h0;
  localparam logic [1:0] RQ_WRITE = 2'h1;
  localparam logic [1:0] RQ_XFER = 2'h2;
  localparam logic [1:0] RQ_SPECIAL = 2'h3;

  // Cycle type codes outside the column phase: idle, row-phase types, open page
  localparam logic [5:0] ST_IDLE = 6'h00;
  localparam logic [5:0] ST_ROW_READ = 6'h01;
  localparam logic [5:0] ST_ROW_WRITE = 6'h02;
  localparam logic [5:0] ST_ROW_XFER = 6'h03;
  localparam logic [5:0] ST_ROW_SPEC = 6'h04;
  localparam logic [5:0] ST_ROW_PAGE = 6'h05;

  // Endian mode sampled at reset release
  localparam logic ENDIAN_LITTLE = 1'b0;

  typedef enum logic [2:0] {
    LMB_IDLE,
    LMB_ROW,
    LMB_RCD,
    LMB_COL,
    LMB_PRE
  } lmb_state_t;

endpackage

// >>> lmb_port.sv
// Local memory bus port: address, data, strobes and status for DRAM,
// VRAM and SDRAM. Assumes glue logic answers sizing, page, shift,
// timing, ready, retry and fault inputs synchronously to i_clk.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Drive 32-bit byte address, row/column multiplexed
// - Column address shifted by one of eight
// - Bus width input sizes transfers dynamically
// - Cycle timing code shapes memory cycle
// - Up to 64 data bits each cycle
// - Drive transceiver enable, active low
// - Direction low inbound, high outbound
// - Page size decides new row access
// - Ready low inserts wait states
// - Row latch falls on valid address
// - Retry low abandons and reschedules cycle
// - Status gives row type, then requester
// - Custom timing alters row, column strobes
// - Custom timing level at reset sets endian
// - Eight byte-lane column strobes
// - Special function output for VRAM ops
// - Single row address strobe output
// - Output enable, transfer or SDRAM CAS
// - Write enable low before column strobes
// - Endian sampled at reset release edge
// - Outputs registered on one clock, except request ready and the output clock
module lmb_port (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // Internal request side
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [1:0] i_req_type,
  input wire logic [3:0] i_req_source,
  input wire logic [31:0] i_req_addr,
  input wire logic [63:0] i_req_wdata,
  input wire logic [7:0] i_req_lanes,
  output logic o_done,
  output logic o_fault,
  output logic [63:0] o_rdata,
  output logic o_endian_mode,
  // Memory side
  input wire logic [2:0] i_col_addr_shift_sel,
  input wire logic [1:0] i_bus_width_sel,
  input wire logic [2:0] i_cycle_timing_sel,
  input wire logic [3:0] i_page_size_sel,
  input wire logic i_ready,
  input wire logic i_retry_n,
  input wire logic i_fault_n,
  input wire logic i_custom_timing_sel,
  input wire logic [63:0] i_mem_data_io,
  output logic [63:0] o_mem_data_io,
  output logic o_mem_data_io_oe_n,
  output logic [31:0] o_mem_addr_out,
  output logic o_xcvr_enable_n,
  output logic o_xcvr_direction,
  output logic o_row_addr_latch,
  output logic [5:0] o_cycle_type_code,
  output logic [7:0] o_col_strobe_lanes_n,
  output logic o_vram_special_func,
  output logic o_ras_n,
  output logic o_out_enable_or_col_strobe_n,
  output logic o_write_n,
  output logic o_output_clock
);

  // ****************************************
  // Helpers
  // ****************************************
  // Bytes moved per beat for a bus width code
  function automatic logic [3:0] beat_bytes(input logic [1:0] bw);
    case (bw)
      lmb_pkg::BW_8: beat_bytes = 4'h1;
      lmb_pkg::BW_16: beat_bytes = 4'h2;
      lmb_pkg::BW_32: beat_bytes = 4'h4;
      default: beat_bytes = 4'h8;
    endcase
  endfunction

  // Row compare mask: page of 2^(ps+8) bytes
  function automatic logic [31:0] page_mask(input logic [3:0] ps);
    page_mask = 32'hffffffff << (5'(ps) + 5'h08);
  endfunction

  lmb_pkg::lmb_state_t state_r;
  logic [31:0] addr_r;
  logic [31:0] open_row_r;
  logic row_open_r;
  logic [1:0] type_r;
  logic [3:0] src_r;
  logic [63:0] wdata_r;
  logic [7:0] lanes_r;
  logic [3:0] cnt_r;
  logic [3:0] bytes_left_r;
  logic [3:0] offs_r;
  logic endian_r;
  logic in_reset_r;
  logic is_wr;
  logic [3:0] bb;
  logic [31:0] col_addr;
  logic new_row;

  assign is_wr = (type_r == lmb_pkg::RQ_WRITE);
  assign bb = beat_bytes(i_bus_width_sel);
  assign col_addr = (addr_r + 32'(offs_r)) >> i_col_addr_shift_sel;
  assign new_row = !row_open_r ||
    ((i_req_addr & page_mask(i_page_size_sel)) !=
     (open_row_r & page_mask(i_page_size_sel)));
  assign o_req_ready = i_clk_en && (state_r == lmb_pkg::LMB_IDLE) &&
    !in_reset_r;
  // Output clock mirrors the core clock; outputs all launch on i_clk
  assign o_output_clock = i_clk;

  // ****************************************
  // Endian strap
  // ****************************************
  // Sampled on the first enabled cycle out of reset, not under reset
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      in_reset_r <= 1'b1;
      endian_r <= lmb_pkg::ENDIAN_LITTLE;
    end else if (i_clk_en && in_reset_r) begin
      in_reset_r <= 1'b0;
      endian_r <= i_custom_timing_sel;
    end
  end
  assign o_endian_mode = endian_r;

  // ****************************************
  // Cycle sequencer
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_r <= lmb_pkg::LMB_IDLE;
      addr_r <= 32'h0;
      open_row_r <= 32'h0;
      row_open_r <= 1'b0;
      type_r <= lmb_pkg::RQ_READ;
      src_r <= 4'h0;
      wdata_r <= 64'h0;
      lanes_r <= 8'h0;
      cnt_r <= 4'h0;
      bytes_left_r <= 4'h0;
      offs_r <= 4'h0;
      o_done <= 1'b0;
      o_fault <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      o_fault <= 1'b0;
      case (state_r)
        lmb_pkg::LMB_IDLE: begin
          if (i_req_valid && !in_reset_r) begin
            addr_r <= i_req_addr;
            type_r <= i_req_type;
            src_r <= i_req_source;
            wdata_r <= i_req_wdata;
            lanes_r <= i_req_lanes;
            offs_r <= 4'h0;
            bytes_left_r <= 4'h8;
            if (new_row) begin
              // Close any open page before opening another
              cnt_r <= lmb_pkg::PRE_CNT;
              state_r <= row_open_r ? lmb_pkg::LMB_PRE : lmb_pkg::LMB_ROW;
            end else begin
              // Page hit: the data pins need one cycle to turn on first
              cnt_r <= 4'(i_cycle_timing_sel);
              state_r <= lmb_pkg::LMB_COL;
            end
          end
        end
        lmb_pkg::LMB_PRE: begin
          row_open_r <= 1'b0;
          if (cnt_r <= 4'h1) begin
            state_r <= lmb_pkg::LMB_ROW;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        lmb_pkg::LMB_ROW: begin
          open_row_r <= addr_r;
          row_open_r <= 1'b1;
          // Custom timing stretches the row-to-column delay by one
          cnt_r <= lmb_pkg::RCD_CNT + 4'(i_custom_timing_sel);
          state_r <= lmb_pkg::LMB_RCD;
        end
        lmb_pkg::LMB_RCD: begin
          if (!i_fault_n) begin
            // Row fault ends the access at once
            o_fault <= 1'b1;
            row_open_r <= 1'b0;
            state_r <= lmb_pkg::LMB_IDLE;
          end else if (cnt_r <= 4'h1) begin
            cnt_r <= 4'(i_cycle_timing_sel);
            state_r <= lmb_pkg::LMB_COL;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        lmb_pkg::LMB_COL: begin
          if (!i_retry_n) begin
            // Busy memory: drop the row, request is replayed later
            row_open_r <= 1'b0;
            cnt_r <= lmb_pkg::PRE_CNT;
            offs_r <= 4'h0;
            bytes_left_r <= 4'h8;
            state_r <= lmb_pkg::LMB_PRE;
          end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (i_ready && !o_xcvr_enable_n) begin
            // Beat ends only once the pins have stood a full cycle
            if (bytes_left_r <= bb) begin
              o_done <= 1'b1;
              state_r <= lmb_pkg::LMB_IDLE;
            end else begin
              bytes_left_r <= bytes_left_r - bb;
              offs_r <= offs_r + bb;
              cnt_r <= 4'(i_cycle_timing_sel);
            end
          end
        end
        default: state_r <= lmb_pkg::LMB_IDLE;
      endcase
    end
  end

  // ****************************************
  // Registered pin drivers
  // ****************************************
  logic col_ph;
  logic row_ph;
  logic [63:0] wdata_sh;
  assign col_ph = (state_r == lmb_pkg::LMB_COL) && i_retry_n;
  assign row_ph = (state_r == lmb_pkg::LMB_ROW) ||
    (state_r == lmb_pkg::LMB_RCD);
  // Narrow buses carry the current slice on the low lanes
  assign wdata_sh = wdata_r >> (8 * offs_r);

  // ****************************************
  // Read lanes
  // ****************************************
  // Each byte lane takes its slice from the low lanes of a narrow bus
  generate
    for (genvar k = 0; k < lmb_pkg::LANES; k++) begin : g_rd_lane
      logic [3:0] src_lane;
      logic take;
      assign src_lane = 4'(k) - offs_r;
      assign take = col_ph && (cnt_r == 4'h0) && i_ready &&
        !o_xcvr_enable_n && !is_wr && (4'(k) >= offs_r) && (src_lane < bb);
      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          o_rdata[8*k +: 8] <= 8'h00;
        end else if (i_clk_en && take) begin
          o_rdata[8*k +: 8] <= i_mem_data_io[8*src_lane[2:0] +: 8];
        end
      end
    end
  endgenerate

  // ****************************************
  // Address and row pins
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_mem_addr_out <= 32'h0;
      o_row_addr_latch <= 1'b0;
      o_ras_n <= 1'b1;
    end else if (i_clk_en) begin
      o_mem_addr_out <= col_ph ? col_addr : addr_r;
      // High in the row cycle, falls once the address is stable
      o_row_addr_latch <= (state_r == lmb_pkg::LMB_ROW);
      // Custom timing holds the row strobe off in the first row cycle
      o_ras_n <= !(row_open_r || ((state_r == lmb_pkg::LMB_ROW) &&
        !i_custom_timing_sel));
    end
  end

  // ****************************************
  // Column and control strobes
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_col_strobe_lanes_n <= 8'hff;
      o_out_enable_or_col_strobe_n <= 1'b1;
      o_write_n <= 1'b1;
      o_vram_special_func <= 1'b0;
    end else if (i_clk_en) begin
      // Strobes wait one cycle behind write enable and the data pins,
      // so even a page hit has write enable low first
      o_col_strobe_lanes_n <= (col_ph && cnt_r == 4'h0 &&
        !o_xcvr_enable_n) ? ~lanes_r : 8'hff;
      o_out_enable_or_col_strobe_n <= !(col_ph &&
        (!is_wr || type_r == lmb_pkg::RQ_XFER));
      // Write enable goes low from the row phase, ahead of the strobes
      o_write_n <= !((row_ph || col_ph) && is_wr);
      o_vram_special_func <= (row_ph || col_ph) &&
        (type_r == lmb_pkg::RQ_SPECIAL);
    end
  end

  // ****************************************
  // Data pins and transceivers
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_xcvr_enable_n <= 1'b1;
      o_xcvr_direction <= 1'b0;
      o_mem_data_io <= 64'h0;
      o_mem_data_io_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      o_xcvr_enable_n <= !col_ph;
      o_xcvr_direction <= col_ph && is_wr;
      o_mem_data_io <= wdata_sh;
      o_mem_data_io_oe_n <= !(col_ph && is_wr);
    end
  end

  // ****************************************
  // Status code
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_cycle_type_code <= lmb_pkg::ST_IDLE;
    end else if (i_clk_en) begin
      if (col_ph) begin
        o_cycle_type_code <= {src_r, type_r};
      end else if (row_ph) begin
        case (type_r)
          lmb_pkg::RQ_READ: o_cycle_type_code <= lmb_pkg::ST_ROW_READ;
          lmb_pkg::RQ_WRITE: o_cycle_type_code <= lmb_pkg::ST_ROW_WRITE;
          lmb_pkg::RQ_XFER: o_cycle_type_code <= lmb_pkg::ST_ROW_XFER;
          default: o_cycle_type_code <= lmb_pkg::ST_ROW_SPEC;
        endcase
      end else begin
        o_cycle_type_code <= row_open_r ? lmb_pkg::ST_ROW_PAGE :
          lmb_pkg::ST_IDLE;
      end
    end
  end

endmodule

`default_nettype wire

// >>> lmb_port_sva.sv
// Checker: timing relations at the local memory bus pins.
// Assumes i_clk_en is held high, so pins move on every edge.
`timescale 1ns/1ps
`default_nettype none
module lmb_port_sva (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ready,
  input wire logic i_retry_n,
  input wire logic i_fault_n,
  input wire logic i_custom_timing_sel,
  input wire logic o_done,
  input wire logic o_fault,
  input wire logic o_endian_mode,
  input wire logic o_mem_data_io_oe_n,
  input wire logic o_xcvr_direction,
  input wire logic o_row_addr_latch,
  input wire logic [5:0] o_cycle_type_code,
  input wire logic [7:0] o_col_strobe_lanes_n,
  input wire logic o_ras_n,
  input wire logic o_write_n
);
  // ****************
  // Pin relations
  // ****************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  property p_done_one; o_done |=> !o_done; endproperty
  a_done_one: assert property (p_done_one)
    else $error("done held too long");
  property p_wait; o_done |-> $past(i_ready); endproperty
  a_wait: assert property (p_wait)
    else $error("done while memory waited");
  property p_retry; o_done |-> $past(i_retry_n); endproperty
  a_retry: assert property (p_retry)
    else $error("done on a retried cycle");
  property p_fault; o_fault |-> !$past(i_fault_n); endproperty
  a_fault: assert property (p_fault)
    else $error("fault without cause");
  property p_endian;
    $rose(i_nrst) |=> o_endian_mode == $past(i_custom_timing_sel);
  endproperty
  a_endian: assert property (p_endian)
    else $error("endian not taken at release");
  property p_lanes_ras; !(&o_col_strobe_lanes_n) |-> !o_ras_n; endproperty
  a_lanes_ras: assert property (p_lanes_ras)
    else $error("column strobe without row strobe");
  property p_we_first;
    $fell(&o_col_strobe_lanes_n) && !o_write_n |-> !$past(o_write_n);
  endproperty
  a_we_first: assert property (p_we_first)
    else $error("write enable not ahead of column strobe");
  property p_dir; !o_mem_data_io_oe_n |-> o_xcvr_direction; endproperty
  a_dir: assert property (p_dir)
    else $error("driving data with inward direction");
  property p_row_code;
    o_row_addr_latch |-> o_cycle_type_code inside
      {[lmb_pkg::ST_ROW_READ:lmb_pkg::ST_ROW_PAGE]};
  endproperty
  a_row_code: assert property (p_row_code)
    else $error("row status code out of range");
endmodule
bind lmb_port lmb_port_sva i_sva (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_ready(i_ready), .i_retry_n(i_retry_n), .i_fault_n(i_fault_n),
  .i_custom_timing_sel(i_custom_timing_sel), .o_done(o_done),
  .o_fault(o_fault), .o_endian_mode(o_endian_mode),
  .o_mem_data_io_oe_n(o_mem_data_io_oe_n),
  .o_xcvr_direction(o_xcvr_direction), .o_row_addr_latch(o_row_addr_latch),
  .o_cycle_type_code(o_cycle_type_code),
  .o_col_strobe_lanes_n(o_col_strobe_lanes_n), .o_ras_n(o_ras_n),
  .o_write_n(o_write_n));
`default_nettype wire

// >>> lmb_mem_model.sv
// Memory model: DRAM-like far side answering the port's strobes.
// Assumes the bench resolves the split data pins into one bus.
`timescale 1ns/1ps
`default_nettype none
module lmb_mem_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic [31:0] i_addr,
  input wire logic i_row_latch,
  input wire logic i_oe_n,
  input wire logic i_write_n,
  input wire logic [7:0] i_lanes_n,
  input wire logic [63:0] i_data,
  output logic o_ready,
  output logic [63:0] o_data,
  output logic [31:0] o_row,
  output logic [63:0] o_wr_data,
  output logic [7:0] o_wr_lanes_n
);
  // ****************
  // Behaviour
  // ****************
  initial begin
    o_ready = 1'b1;
    o_data = '0;
  end
  always @(negedge i_clk) begin
    // Slow mode stretches columns with wait states
    o_ready <= i_slow ? ($urandom % 4 == 0) : ($urandom % 4 != 0);
    // Released bus keeps changing so a stale sample cannot match
    o_data <= (!i_oe_n && i_write_n) ? {o_row, ~o_row} : ~o_data;
    if (i_row_latch) o_row <= i_addr;
    if (!i_write_n && !(&i_lanes_n)) begin
      o_wr_data <= i_data;
      o_wr_lanes_n <= i_lanes_n;
    end
  end
endmodule
`default_nettype wire

// >>> lmb_tb.sv
// Bench: random and directed cycles through the local memory bus port.
// Assumes the memory model and the bound checker sit beside the port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************
  // Signals
  // ****************
  logic clk = 1'b0, nrst = 1'b0, valid = 1'b0, slow = 1'b0, chk_on = 1'b1;
  logic retry_n = 1'b1, fault_n = 1'b1, custom_timing_sel = 1'b1;
  logic [1:0] rtype = '0, bw = '0, e_k;
  logic [2:0] shift = '0, ct = '0;
  logic [3:0] ps = '0, src = '0;
  logic [31:0] addr = '0, maddr, row, e_a;
  logic [63:0] wdata = '0, rdata, dout, mdata, wrd, din, e_d;
  logic [7:0] lanes = '0, cas_n, wrl, e_l;
  logic rdy, done, fault, endian, doe_n, xen_n, xdir, rl, vram_special_func, ras_n;
  logic trg_n, we_n, oclk, mready;
  logic [5:0] stat;
  logic [31:0] q_a[$];
  logic [63:0] q_d[$];
  logic [7:0] q_l[$];
  logic [1:0] q_k[$];
  int error_cnt = 0, tests_run = 0, cyc = 0, i;
  assign din = doe_n ? mdata : dout;
  initial forever #20 clk = ~clk;
  lmb_port i_dut (.i_clk(clk), .i_nrst(nrst), .i_clk_en(1'b1),
    .i_req_valid(valid), .o_req_ready(rdy), .i_req_type(rtype),
    .i_req_source(src), .i_req_addr(addr), .i_req_wdata(wdata),
    .i_req_lanes(lanes), .o_done(done), .o_fault(fault), .o_rdata(rdata),
    .o_endian_mode(endian), .i_col_addr_shift_sel(shift),
    .i_bus_width_sel(bw), .i_cycle_timing_sel(ct), .i_page_size_sel(ps),
    .i_ready(mready), .i_retry_n(retry_n), .i_fault_n(fault_n),
    .i_custom_timing_sel(custom_timing_sel), .i_mem_data_io(din),
    .o_mem_data_io(dout), .o_mem_data_io_oe_n(doe_n),
    .o_mem_addr_out(maddr), .o_xcvr_enable_n(xen_n),
    .o_xcvr_direction(xdir), .o_row_addr_latch(rl),
    .o_cycle_type_code(stat), .o_col_strobe_lanes_n(cas_n),
    .o_vram_special_func(vram_special_func), .o_ras_n(ras_n),
    .o_out_enable_or_col_strobe_n(trg_n), .o_write_n(we_n),
    .o_output_clock(oclk));
  lmb_mem_model i_mem (.i_clk(clk), .i_slow(slow), .i_addr(maddr),
    .i_row_latch(rl), .i_oe_n(trg_n), .i_write_n(we_n), .i_lanes_n(cas_n),
    .i_data(din), .o_ready(mready), .o_data(mdata), .o_row(row),
    .o_wr_data(wrd), .o_wr_lanes_n(wrl));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string what, input logic [63:0] e, logic [63:0] g);
    tests_run++;
    if (e !== g) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_sim;
    $display("TB: errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rst(input logic strap);
    @(posedge clk);
    nrst <= 1'b0;
    custom_timing_sel <= strap;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("endian", strap, endian);
  endtask
  // Narrow widths, transfers and specials only check the latched row address
  task automatic req(input logic [1:0] t, input logic [1:0] w);
    logic [31:0] a;
    logic [63:0] d;
    logic [7:0] l;
    a = $urandom;
    d = {$urandom, $urandom};
    l = 8'($urandom) | 8'h01;
    if (chk_on) begin
      q_a.push_back(a);
      q_d.push_back(t == lmb_pkg::RQ_READ ? {a, ~a} : d);
      q_l.push_back(~l);
      q_k.push_back((w == lmb_pkg::BW_64 && t < 2'h2) ? t : 2'h2);
    end
    @(posedge clk);
    {rtype, bw, addr, wdata, lanes} <= {t, w, a, d, l};
    // Pages kept small so random addresses never hit an open page
    {shift, ct, ps[2:0], custom_timing_sel, src} <= 14'($urandom);
    valid <= 1'b1;
    for (int n = 0; n < 200; n++) begin
      @(negedge clk);
      if (rdy === 1'b1) break;
    end
    @(posedge clk);
    valid <= 1'b0;
  endtask
  task automatic drain;
    for (int n = 0; n < 500 && q_a.size() > 0; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("pending", 0, q_a.size());
  endtask
  // ****************
  // Checking and stimulus
  // ****************
  always @(negedge clk) begin
    if (done === 1'b1 && chk_on) begin
      repeat (2) @(posedge clk);
      if (q_a.size() == 0) chk("extra done", 0, 1);
      else begin
        e_a = q_a.pop_front();
        e_d = q_d.pop_front();
        e_l = q_l.pop_front();
        e_k = q_k.pop_front();
        chk("row addr", e_a, row);
        if (e_k == 2'h0) chk("rdata", e_d, rdata);
        if (e_k == 2'h1) chk("wdata", e_d, wrd);
        if (e_k == 2'h1) chk("lanes", e_l, wrl);
      end
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    void'($urandom(16013));
    rst(1'b1);
    for (i = 0; i < 16; i++) req(i[1:0], i[3:2]);
    for (i = 0; i < 16; i++) begin
      slow <= i[3];
      req(2'(i % 2), lmb_pkg::BW_64);
    end
    fork
      req(lmb_pkg::RQ_READ, lmb_pkg::BW_64);
      begin
        repeat (4) @(posedge clk);
        retry_n <= 1'b0;
        repeat (2) @(posedge clk);
        retry_n <= 1'b1;
      end
    join
    slow <= 1'b0;
    drain();
    chk_on = 1'b0;
    fork
      req(lmb_pkg::RQ_READ, lmb_pkg::BW_64);
      begin
        fault_n <= 1'b0;
        for (i = 0; i < 40 && fault !== 1'b1; i++) @(negedge clk);
        chk("fault", 1, fault);
        @(posedge clk);
        fault_n <= 1'b1;
      end
    join
    for (i = 0; i < 200 && rdy !== 1'b1; i++) @(negedge clk);
    chk_on = 1'b1;
    rst(1'b0);
    for (i = 0; i < 4; i++) req(2'(i), lmb_pkg::BW_64);
    drain();
    end_sim();
  end
endmodule
`default_nettype wire
